// *** logic/link_control_register.sv ***
// link control register of one switch port, with the unlock bit of the switch control register
// assumes same-clock register strobes and an external training state machine that
// samples the per-cycle training controls
//
// The implementer's own choice: the address-and-strobe port.

`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
module link_control_register (
	// clock and reset
	input  wire logic        ref_clk,
	input  wire logic        sys_rst,
	// port strap, static
	input  wire logic        isUpstream,
	// eeprom override of power management field
	input  wire logic        eepromLoad,
	input  wire logic [1:0]  eepromAspm,
	// register port
	input  wire logic [11:0] regAddr,
	input  wire logic [15:0] regWrData,
	input  wire logic        regWrite,
	input  wire logic        regRead,
	output logic      [15:0] regRdData,
	// training state machine controls
	output logic             allowL0s,
	output logic             allowL1,
	output logic             linkDisable,
	output logic             retrainRequest,
	output logic             sharedRefclk,
	output logic             extendedSync
);

	////////////////////////////////////////////////////////////////////////////
	logic [1:0] aspmControl;
	logic       linkDisableBit;
	logic       sharedRefclkFlag;
	logic       extendedSyncEnable;
	logic       configUnlockBit;
	logic       strapMeta;
	logic       strapUpstream;
	logic       ctlWrite;
	logic       swWrite;
	logic       retrainAllowed;

	// shared by the write strobes and the read path
	function automatic logic hitsOffset(input logic [11:0] addr, input logic [11:0] ofs);
		return addr == ofs;
	endfunction : hitsOffset

	assign ctlWrite = regWrite && hitsOffset(regAddr, link_control_pkg::LINK_CONTROL_REGISTER_OFS);
	assign swWrite = regWrite && hitsOffset(regAddr, link_control_pkg::SWITCH_CONTROL_REGISTER_OFS);
	// upstream retrain only while unlocked
	assign retrainAllowed = !strapUpstream || configUnlockBit;

	// strap is a pin: two flops before use, caught only after reset release
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			strapMeta     <= 1'h0;
			strapUpstream <= 1'h0;
		end else begin
			strapMeta     <= isUpstream;
			strapUpstream <= strapMeta;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// power management field
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			aspmControl <= link_control_pkg::ASPM_RESET;
		end else if (ctlWrite) begin
			aspmControl <= regWrData[link_control_pkg::ASPM_MSB:link_control_pkg::ASPM_LSB];
		end else if (eepromLoad) begin
			aspmControl <= eepromAspm;
		end
	end

	// writable control bits
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			linkDisableBit     <= link_control_pkg::LINK_DISABLE_RESET;
			sharedRefclkFlag   <= link_control_pkg::SHARED_REFCLK_RESET;
			extendedSyncEnable <= link_control_pkg::EXTENDED_SYNC_RESET;
		end else if (ctlWrite) begin
			linkDisableBit     <= regWrData[link_control_pkg::LINK_DISABLE_BIT_POS];
			sharedRefclkFlag   <= regWrData[link_control_pkg::SHARED_REFCLK_FLAG_POS];
			extendedSyncEnable <= regWrData[link_control_pkg::EXTENDED_SYNC_ENABLE_POS];
		end
	end

	// unlock bit of the switch control register
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			configUnlockBit <= link_control_pkg::CONFIG_UNLOCK_RESET;
		end else if (swWrite) begin
			configUnlockBit <= regWrData[link_control_pkg::CONFIG_UNLOCK_BIT_POS];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// retrain pulse registered with the fields, so the same write's settings
	// are already in place when training sees it
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			retrainRequest <= 1'h0;
		end else begin
			retrainRequest <= ctlWrite && retrainAllowed
				&& regWrData[link_control_pkg::LINK_RETRAIN_TRIGGER_POS];
		end
	end

	// training controls driven straight from the stored fields, link disable gated off by the upstream strap
	always_comb begin
		allowL0s = 1'h0;
		allowL1 = 1'h0;
		case (link_control_pkg::aspm_mode_t'(aspmControl))
			link_control_pkg::ASPM_DISABLED: begin
				allowL0s = 1'h0;
				allowL1 = 1'h0;
			end
			link_control_pkg::ASPM_L0S: begin
				allowL0s = 1'h1;
			end
			link_control_pkg::ASPM_L1: begin
				allowL1 = 1'h1;
			end
			link_control_pkg::ASPM_L0S_L1: begin
				allowL0s = 1'h1;
				allowL1 = 1'h1;
			end
			default: begin
				allowL0s = 1'h0;
				allowL1 = 1'h0;
			end
		endcase
	end

	assign linkDisable = linkDisableBit && !strapUpstream;
	assign sharedRefclk = sharedRefclkFlag;
	assign extendedSync = extendedSyncEnable;

	////////////////////////////////////////////////////////////////////////////
	// read path: unmapped addresses return zero
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			regRdData <= 16'h0000;
		end else if (regRead) begin
			regRdData <= 16'h0000;
			if (hitsOffset(regAddr, link_control_pkg::LINK_CONTROL_REGISTER_OFS)) begin
				regRdData[link_control_pkg::ASPM_MSB:link_control_pkg::ASPM_LSB] <= aspmControl;
				regRdData[link_control_pkg::RCB_BIT] <= 1'h0;
				regRdData[link_control_pkg::LINK_DISABLE_BIT_POS] <= linkDisableBit;
				regRdData[link_control_pkg::LINK_RETRAIN_TRIGGER_POS] <= 1'h0;
				regRdData[link_control_pkg::SHARED_REFCLK_FLAG_POS] <= sharedRefclkFlag;
				regRdData[link_control_pkg::EXTENDED_SYNC_ENABLE_POS] <= extendedSyncEnable;
				regRdData[link_control_pkg::CLOCK_PM_ENABLE_POS] <= 1'h0;
			end else if (hitsOffset(regAddr, link_control_pkg::SWITCH_CONTROL_REGISTER_OFS)) begin
				regRdData[link_control_pkg::CONFIG_UNLOCK_BIT_POS] <= configUnlockBit;
			end
		end else begin
			regRdData <= 16'h0000;
		end
	end

endmodule : link_control_register

// *** logic/link_control_pkg.sv ***
// constants for the per-port link control register block
// assumes a single core clock and a plain strobe register port

package link_control_pkg;

	// register map (byte offsets)
	localparam logic [11:0] LINK_CONTROL_REGISTER_OFS = 12'h050;
	localparam logic [11:0] SWITCH_CONTROL_REGISTER_OFS = 12'h0a0;

	// link control field positions
	localparam int ASPM_LSB = 0;
	localparam int ASPM_MSB = 1;
	localparam int RCB_BIT = 3;
	localparam int LINK_DISABLE_BIT_POS = 4;
	localparam int LINK_RETRAIN_TRIGGER_POS = 5;
	localparam int SHARED_REFCLK_FLAG_POS = 6;
	localparam int EXTENDED_SYNC_ENABLE_POS = 7;
	localparam int CLOCK_PM_ENABLE_POS = 8;

	// switch control field positions
	localparam int CONFIG_UNLOCK_BIT_POS = 0;

	// reset values
	localparam logic [1:0] ASPM_RESET = 2'h0;
	localparam logic LINK_DISABLE_RESET = 1'h0;
	localparam logic SHARED_REFCLK_RESET = 1'h0;
	localparam logic EXTENDED_SYNC_RESET = 1'h0;
	localparam logic CONFIG_UNLOCK_RESET = 1'h0;

	// power management entry encodings
	typedef enum logic [1:0] {
		ASPM_DISABLED = 2'h0,
		ASPM_L0S      = 2'h1,
		ASPM_L1       = 2'h2,
		ASPM_L0S_L1   = 2'h3
	} aspm_mode_t;

endpackage : link_control_pkg

// *** testbench/link_ctl_assertions.sv ***
// port assertions for the link control register block
// assumes one clock, async high reset, strap held steady
`timescale 1ns/1ps
module link_ctl_assertions (
	input wire logic        ref_clk, sys_rst, isUpstream, eepromLoad, regWrite, regRead,
	input wire logic [1:0]  eepromAspm,
	input wire logic [11:0] regAddr,
	input wire logic [15:0] regWrData, regRdData,
	input wire logic        allowL0s, allowL1, linkDisable, retrainRequest, sharedRefclk, extendedSync
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (sys_rst);
	logic wr;
	assign wr = regWrite && regAddr == 12'h050;
	////////////////////////////////////////
	a_aspm_decode: assert property (wr |=> {allowL1, allowL0s} == $past(regWrData[1:0]))
		else $error("aspm mismatch");
	a_eeprom_load: assert property (eepromLoad && !wr |=> {allowL1, allowL0s} == $past(eepromAspm))
		else $error("eeprom load lost");
	a_retrain_cause: assert property (retrainRequest |-> $past(wr && regWrData[5]))
		else $error("retrain without write");
	a_retrain_down: assert property (wr && regWrData[5] && !$past(isUpstream, 2) |=> retrainRequest)
		else $error("retrain missing");
	a_read_mask: assert property ($past(regRead && regAddr == 12'h050) |-> (regRdData & 16'hff2c) == 16'h0)
		else $error("fixed bit reads one");
	// strap passes two registers first, so two cycles of history
	a_up_inert: assert property (isUpstream && $past(isUpstream) && $past(isUpstream, 2) |-> !linkDisable)
		else $error("upstream link disabled");
	a_down_disable: assert property (wr && !$past(isUpstream) |=> linkDisable == $past(regWrData[4]))
		else $error("link disable wrong");
	a_refclk_write: assert property (wr |=> sharedRefclk == $past(regWrData[6]))
		else $error("refclk flag wrong");
	a_extended_sync_enable_write: assert property (wr |=> extendedSync == $past(regWrData[7]))
		else $error("ext sync wrong");
endmodule : link_ctl_assertions
bind link_control_register link_ctl_assertions link_ctl_assertions_i (.ref_clk, .sys_rst, .isUpstream, .eepromLoad,
	.regWrite, .regRead, .eepromAspm, .regAddr, .regWrData, .regRdData, .allowL0s, .allowL1, .linkDisable,
	.retrainRequest, .sharedRefclk, .extendedSync);

// *** testbench/test_link_control_register.sv ***
// self-checking bench for the link control register
// assumes the design answers reads one cycle after the strobe
`timescale 1ns/1ps
module test_link_control_register;
	logic        ref_clk = 1'h0, sys_rst = 1'h1, isUpstream = 1'h0, eepromLoad = 1'h0, regWrite = 1'h0;
	logic        regRead = 1'h0, allowL0s, allowL1, linkDisable, retrainRequest, sharedRefclk, extendedSync;
	logic [1:0]  eepromAspm = 2'h0;
	logic [11:0] regAddr = 12'h0;
	logic [15:0] regWrData = 16'h0, regRdData;
	int          fails = 0, n_compared = 0;
	always #25 ref_clk = ~ref_clk;
	link_control_register link_control_register_i (.ref_clk, .sys_rst, .isUpstream, .eepromLoad, .eepromAspm,
		.regAddr, .regWrData, .regWrite, .regRead, .regRdData, .allowL0s, .allowL1, .linkDisable,
		.retrainRequest, .sharedRefclk, .extendedSync);
	////////////////////////////////////////
	task chk(input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp) begin
			fails++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task wr(input logic [11:0] a, input logic [15:0] d);
		@(posedge ref_clk);
		regWrite <= 1'h1;
		regAddr <= a;
		regWrData <= d;
		@(posedge ref_clk);
		regWrite <= 1'h0;
		#1;
	endtask : wr
	task rd(input logic [11:0] a, input logic [15:0] e);
		@(posedge ref_clk);
		regRead <= 1'h1;
		regAddr <= a;
		@(posedge ref_clk);
		regRead <= 1'h0;
		#1 chk(regRdData, e);
	endtask : rd
	task summarize;
		$display("compared %0d failed %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : summarize
	initial begin
		repeat (8) @(posedge ref_clk);
		sys_rst <= 1'h0;
		rd(12'h050, 16'h0000);
		chk({allowL1, allowL0s, sharedRefclk, extendedSync}, 16'h0);
		for (int i = 0; i < 4; i++) begin
			wr(12'h050, 16'(i));
			chk({allowL1, allowL0s}, 16'(i));
		end
		// all ones: fixed bits must drop, trigger fires with new fields
		wr(12'h050, 16'hffff);
		chk({retrainRequest, linkDisable, sharedRefclk, extendedSync}, 16'hf);
		rd(12'h050, 16'h00d3);
		chk(retrainRequest, 16'h0);
		@(posedge ref_clk);
		eepromLoad <= 1'h1;
		eepromAspm <= 2'h2;
		@(posedge ref_clk);
		eepromLoad <= 1'h0;
		rd(12'h050, 16'h00d2);
		@(posedge ref_clk);
		#1 chk(regRdData, 16'h0000);
		@(posedge ref_clk);
		isUpstream <= 1'h1;
		repeat (3) @(posedge ref_clk);
		#1 chk(linkDisable, 16'h0);
		wr(12'h050, 16'h0020);
		chk(retrainRequest, 16'h0);
		wr(12'h0a0, 16'h0001);
		wr(12'h050, 16'h0020);
		chk(retrainRequest, 16'h1);
		rd(12'h050, 16'h0000);
		rd(12'h0fc, 16'h0000);
		rd(12'h0a0, 16'h0001);
		wr(12'h050, 16'h00d3);
		@(posedge ref_clk);
		sys_rst <= 1'h1;
		repeat (2) @(posedge ref_clk);
		sys_rst <= 1'h0;
		rd(12'h050, 16'h0000);
		chk({allowL1, allowL0s, sharedRefclk, extendedSync, linkDisable}, 16'h0);
		rd(12'h0a0, 16'h0000);
		summarize();
	end
endmodule : test_link_control_register
